// >>> logic/adu_pkg.sv
// Constants, field positions and state types of the serial port with receive DMA request
// Functional notes
// [RULE1] tx_data_reg_empty reads 1 when the holding register can take a byte, else 0.
// [RULE2] A written byte moves to the shift register and is sent unprompted.
// [RULE3] No character starts while tx_enable is clear.
// [RULE4] Parity enable and even or odd select apply to transmit and receive.
// [RULE5] With cts_flow_enable set the CTS level gates transmission; otherwise ignored.
// [RULE6] Transmit interrupt is raised while the holding register is free.
// [RULE7] Characters are accepted only while rx_enable is set.
// [RULE8] rx_data_available reads 1 when the receive register holds a byte.
// [RULE9] Multiprocessor mode shows the last received address flag as last_addr_bit_rx.
// [RULE10] Receive interrupt for new data, errors and break; source readable in status.
// [RULE11] rx_data_irq_enable clear masks only the data source of the receive interrupt.
// [RULE12] A received byte raises a transfer request toward the DMA controller.
// [RULE13] The DMA controller takes the bus, copies the byte and releases the bus.
// [RULE14] Errors and break still raise the receive interrupt during DMA service.
// [RULE15] The address flag is sent after the eight data bits, before stop bits.
// [RULE16] In multiprocessor mode the ninth bit is the address flag, parity unavailable.
// [RULE17] Multiprocessor mode is set in control 1 and reported in status 1.
// [RULE18] Bit rate divisor sits in high and low byte registers written by software.
// [RULE19] Transmit service software writes the next byte then clears its pending request.
// [RULE20] Eight data bits LSB first, low start bit, one or two high stop bits.
// [RULE21] Bit rate is the system clock over sixteen times the 16-bit divisor.
// [RULE22] Writing the holding register clears the empty flag and the transmit request.
// [RULE23] Receiver finds the start edge, checks it at mid-bit and samples bits mid-cell.
package adu_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_STAT0 = 3'h1;
    localparam logic [2:0] REG_CTRL0 = 3'h2;
    localparam logic [2:0] REG_CTRL1 = 3'h3;
    localparam logic [2:0] REG_STAT1 = 3'h4;
    localparam logic [2:0] REG_BRG_HI = 3'h5;
    localparam logic [2:0] REG_BRG_LO = 3'h6;

    // Control 0 bit positions
    localparam int C0_TX_EN = 7;
    localparam int C0_RX_EN = 6;
    localparam int C0_CTS_EN = 5;
    localparam int C0_PAR_EN = 4;
    localparam int C0_PAR_ODD = 3;
    localparam int C0_TWO_STOP = 1;
    // Control 1 bit positions
    localparam int C1_MP_EN = 7;
    localparam int C1_TX_ADDR = 6;
    localparam int C1_RDA_IRQ = 3;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] BRG_RST = 16'h0001;
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} adu_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} adu_rx_state_type;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic cts_flow_enable;
        logic par_en;
        logic par_odd;
        logic two_stop;
        logic mp_en;
        logic tx_addr_flag;
        logic rx_data_irq_enable;
        logic [15:0] brg;
    } adu_cfg_type;

    typedef struct packed {
        adu_cfg_type cfg;
        logic cts_s1;
        logic cts_s2;
        logic rxd_s1;
        logic rxd_s2;
        logic rxd_prev;
        logic [15:0] brg_cnt;
        logic tick;
        adu_tx_state_type tx_st;
        logic [3:0] tx_sub;
        logic [2:0] tx_bit;
        logic tx_stop2;
        logic [7:0] tx_hold;
        logic tx_data_reg_empty;
        logic [7:0] tx_shift;
        logic tx_ninth;
        logic txd;
        adu_rx_state_type rx_st;
        logic [3:0] rx_sub;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_ninth;
        logic [7:0] rx_data;
        logic rx_data_available;
        logic pe;
        logic oe;
        logic fe;
        logic brk;
        logic last_addr_bit_rx;
        logic [7:0] rd_data;
        logic tx_irq;
        logic rx_irq;
        logic dma_req;
    } adu_state_type;

endpackage : adu_pkg

// >>> logic/adu_uart.sv
// Serial transmitter and receiver with register port, interrupt lines and DMA request
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module adu_uart
    import adu_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Interrupt and DMA requests
    output logic tx_irq,
    output logic rx_irq,
    output logic dma_req,
    // Serial pins
    output logic txd,
    input wire logic rxd,
    input wire logic cts_n
);

    adu_state_type state_r;
    adu_state_type state_nxt;

    // Parity bit that completes the byte to the selected sense
    function automatic logic par_bit(input logic [7:0] d, input logic odd);
        par_bit = (^d) ^ odd;
    endfunction : par_bit

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.cts_s1 = cts_n;
        state_nxt.cts_s2 = state_r.cts_s1;
        state_nxt.rxd_s1 = rxd;
        state_nxt.rxd_s2 = state_r.rxd_s1;
        state_nxt.rxd_prev = state_r.rxd_s2;

        // Sixteen ticks per bit
        state_nxt.tick = 1'b0;
        if ({1'b0, state_r.brg_cnt} + 17'h00001 >= {1'b0, state_r.cfg.brg}) // RULE21
        begin
            state_nxt.brg_cnt = '0;
            state_nxt.tick = 1'b1;
        end
        else
        begin
            state_nxt.brg_cnt = state_r.brg_cnt + 16'h0001;
        end

        // Register reads; data read clears receive flags
        state_nxt.rd_data = '0;
        if (rd_stb)
        begin
            unique case (addr)
                REG_DATA:
                begin
                    state_nxt.rd_data = state_r.rx_data;
                    state_nxt.rx_data_available = 1'b0;
                    state_nxt.pe = 1'b0;
                    state_nxt.oe = 1'b0;
                    state_nxt.fe = 1'b0;
                    state_nxt.brk = 1'b0;
                    state_nxt.last_addr_bit_rx = 1'b0;
                end
                REG_STAT0: state_nxt.rd_data = {state_r.rx_data_available, state_r.pe,
                    state_r.oe, state_r.fe, state_r.brk, state_r.tx_data_reg_empty, // RULE1 RULE10
                    state_r.tx_st == TX_IDLE, state_r.cts_s2};
                REG_CTRL0: state_nxt.rd_data = {state_r.cfg.tx_enable, state_r.cfg.rx_enable,
                    state_r.cfg.cts_flow_enable, state_r.cfg.par_en, state_r.cfg.par_odd,
                    1'b0, state_r.cfg.two_stop, 1'b0};
                REG_CTRL1: state_nxt.rd_data = {state_r.cfg.mp_en, state_r.cfg.tx_addr_flag,
                    2'h0, state_r.cfg.rx_data_irq_enable, 3'h0};
                REG_STAT1: state_nxt.rd_data = {6'h00, state_r.last_addr_bit_rx, // RULE9
                    state_r.cfg.mp_en}; // RULE17
                REG_BRG_HI: state_nxt.rd_data = state_r.cfg.brg[15:8];
                REG_BRG_LO: state_nxt.rd_data = state_r.cfg.brg[7:0];
                default: state_nxt.rd_data = '0;
            endcase
        end

        // Transmitter
        unique case (state_r.tx_st)
            TX_IDLE:
            begin
                state_nxt.txd = 1'b1;
                if (!state_r.tx_data_reg_empty && state_r.cfg.tx_enable && // RULE3
                    (!state_r.cfg.cts_flow_enable || !state_r.cts_s2)) // RULE5
                begin
                    state_nxt.tx_shift = state_r.tx_hold; // RULE2
                    state_nxt.tx_ninth = state_r.cfg.mp_en ? state_r.cfg.tx_addr_flag // RULE16
                        : par_bit(state_r.tx_hold, state_r.cfg.par_odd); // RULE4
                    state_nxt.tx_data_reg_empty = 1'b1;
                    state_nxt.tx_st = TX_START;
                    state_nxt.tx_sub = '0;
                    state_nxt.txd = 1'b0; // RULE20
                end
            end
            default:
            begin
                if (state_r.tick)
                begin
                    state_nxt.tx_sub = state_r.tx_sub + 4'h1;
                    if (state_r.tx_sub == SUB_LAST)
                    begin
                        unique case (state_r.tx_st)
                            TX_START:
                            begin
                                state_nxt.tx_st = TX_DATA;
                                state_nxt.tx_bit = '0;
                                state_nxt.txd = state_r.tx_shift[0];
                            end
                            TX_DATA:
                            begin
                                if (state_r.tx_bit != BIT_LAST)
                                begin
                                    state_nxt.tx_shift = state_r.tx_shift >> 1; // RULE20
                                    state_nxt.txd = state_r.tx_shift[1];
                                    state_nxt.tx_bit = state_r.tx_bit + 3'h1;
                                end
                                else if (state_r.cfg.par_en || state_r.cfg.mp_en)
                                begin
                                    state_nxt.tx_st = TX_NINTH; // RULE15
                                    state_nxt.txd = state_r.tx_ninth;
                                end
                                else
                                begin
                                    state_nxt.tx_st = TX_STOP;
                                    state_nxt.tx_stop2 = 1'b0;
                                    state_nxt.txd = 1'b1;
                                end
                            end
                            TX_NINTH:
                            begin
                                state_nxt.tx_st = TX_STOP;
                                state_nxt.tx_stop2 = 1'b0;
                                state_nxt.txd = 1'b1;
                            end
                            TX_STOP:
                            begin
                                if (state_r.cfg.two_stop && !state_r.tx_stop2)
                                    state_nxt.tx_stop2 = 1'b1;
                                else
                                    state_nxt.tx_st = TX_IDLE;
                            end
                            default: state_nxt.tx_st = TX_IDLE;
                        endcase
                    end
                end
            end
        endcase

        // Receiver
        if (state_r.rx_st == RX_IDLE)
        begin
            if (state_r.cfg.rx_enable && state_r.rxd_prev && !state_r.rxd_s2) // RULE7 RULE23
            begin
                state_nxt.rx_st = RX_START;
                state_nxt.rx_sub = '0;
                state_nxt.rx_ninth = 1'b0;
            end
        end
        else if (!state_r.cfg.rx_enable)
        begin
            state_nxt.rx_st = RX_IDLE; // RULE7
        end
        else if (state_r.tick)
        begin
            state_nxt.rx_sub = state_r.rx_sub + 4'h1;
            if (state_r.rx_st == RX_START && state_r.rx_sub == SUB_MID)
            begin
                state_nxt.rx_sub = '0;
                state_nxt.rx_bit = '0;
                state_nxt.rx_st = state_r.rxd_s2 ? RX_IDLE : RX_DATA; // RULE23
            end
            else if (state_r.rx_st != RX_START && state_r.rx_sub == SUB_LAST)
            begin
                unique case (state_r.rx_st)
                    RX_DATA:
                    begin
                        state_nxt.rx_shift = {state_r.rxd_s2, state_r.rx_shift[7:1]};
                        state_nxt.rx_bit = state_r.rx_bit + 3'h1;
                        if (state_r.rx_bit == BIT_LAST)
                            state_nxt.rx_st = (state_r.cfg.par_en || state_r.cfg.mp_en)
                                ? RX_NINTH : RX_STOP;
                    end
                    RX_NINTH:
                    begin
                        state_nxt.rx_ninth = state_r.rxd_s2;
                        state_nxt.rx_st = RX_STOP;
                    end
                    RX_STOP:
                    begin
                        // New flags set after the read clear, so a coincident read loses
                        state_nxt.rx_st = RX_IDLE;
                        state_nxt.rx_data = state_r.rx_shift;
                        state_nxt.oe = state_nxt.oe | state_nxt.rx_data_available;
                        state_nxt.rx_data_available = 1'b1; // RULE8
                        state_nxt.fe = state_nxt.fe | !state_r.rxd_s2;
                        state_nxt.pe = state_nxt.pe | (state_r.cfg.par_en && // RULE4
                            !state_r.cfg.mp_en && (state_r.rx_ninth != // RULE16
                            par_bit(state_r.rx_shift, state_r.cfg.par_odd)));
                        state_nxt.brk = state_nxt.brk | (state_r.rx_shift == 8'h00 &&
                            !state_r.rx_ninth && !state_r.rxd_s2);
                        state_nxt.last_addr_bit_rx = state_r.cfg.mp_en && state_r.rx_ninth;
                    end
                    default: state_nxt.rx_st = RX_IDLE;
                endcase
            end
        end

        // Register writes
        if (wr_stb)
        begin
            unique case (addr)
                REG_DATA:
                begin
                    state_nxt.tx_hold = wr_data;
                    state_nxt.tx_data_reg_empty = 1'b0; // RULE22
                end
                REG_CTRL0:
                begin
                    state_nxt.cfg.tx_enable = wr_data[C0_TX_EN];
                    state_nxt.cfg.rx_enable = wr_data[C0_RX_EN];
                    state_nxt.cfg.cts_flow_enable = wr_data[C0_CTS_EN];
                    state_nxt.cfg.par_en = wr_data[C0_PAR_EN];
                    state_nxt.cfg.par_odd = wr_data[C0_PAR_ODD];
                    state_nxt.cfg.two_stop = wr_data[C0_TWO_STOP];
                end
                REG_CTRL1:
                begin
                    state_nxt.cfg.mp_en = wr_data[C1_MP_EN]; // RULE17
                    state_nxt.cfg.tx_addr_flag = wr_data[C1_TX_ADDR];
                    state_nxt.cfg.rx_data_irq_enable = wr_data[C1_RDA_IRQ];
                end
                REG_BRG_HI: state_nxt.cfg.brg[15:8] = wr_data; // RULE18
                REG_BRG_LO: state_nxt.cfg.brg[7:0] = wr_data; // RULE18
                default: state_nxt.cfg = state_r.cfg;
            endcase
        end

        // Requests toward interrupt controller and DMA
        state_nxt.tx_irq = state_nxt.tx_data_reg_empty; // RULE6 RULE22
        state_nxt.rx_irq = (state_nxt.rx_data_available && // RULE11
            state_nxt.cfg.rx_data_irq_enable) || state_nxt.pe || state_nxt.oe ||
            state_nxt.fe || state_nxt.brk; // RULE10 RULE14
        state_nxt.dma_req = state_nxt.rx_data_available; // RULE12
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r <= '0;
            state_r.cfg.brg <= BRG_RST;
            state_r.cts_s1 <= 1'b1;
            state_r.cts_s2 <= 1'b1;
            state_r.rxd_s1 <= 1'b1;
            state_r.rxd_s2 <= 1'b1;
            state_r.rxd_prev <= 1'b1;
            state_r.tx_data_reg_empty <= 1'b1;
            state_r.txd <= 1'b1;
            state_r.tx_irq <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign rd_data = state_r.rd_data;
    assign tx_irq = state_r.tx_irq;
    assign rx_irq = state_r.rx_irq;
    assign dma_req = state_r.dma_req;
    assign txd = state_r.txd;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_tx_data_reg_empty_write;
        wr_stb && addr == REG_DATA |=> !state_r.tx_data_reg_empty && !tx_irq;
    endproperty
    a_tx_data_reg_empty_write: assert property (p_tx_data_reg_empty_write) else $error("empty flag not cleared"); // RULE22

    property p_tx_irq;
        tx_irq == state_r.tx_data_reg_empty;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq not following empty"); // RULE6

    property p_tx_off;
        state_r.tx_st == TX_IDLE && !state_r.cfg.tx_enable |=> state_r.tx_st == TX_IDLE;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmit started while off"); // RULE3

    property p_cts_hold;
        state_r.tx_st == TX_IDLE && state_r.cfg.cts_flow_enable && state_r.cts_s2
            |=> state_r.tx_st == TX_IDLE && txd;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("transmit ignored cts"); // RULE5

    property p_tx_load;
        state_r.tx_st == TX_IDLE && !state_r.tx_data_reg_empty && state_r.cfg.tx_enable &&
            !state_r.cfg.cts_flow_enable && !wr_stb
            |=> state_r.tx_st == TX_START && state_r.tx_data_reg_empty && !txd;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("byte not loaded"); // RULE2

    property p_rx_off;
        state_r.rx_st == RX_IDLE && !state_r.cfg.rx_enable |=> state_r.rx_st == RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receive while off"); // RULE7

    property p_rda_read;
        rd_stb && addr == REG_DATA && state_r.rx_st != RX_STOP
            |=> !state_r.rx_data_available && !dma_req;
    endproperty
    a_rda_read: assert property (p_rda_read) else $error("read did not clear"); // RULE8

    property p_err_irq;
        state_r.rx_st == RX_STOP && state_r.tick && state_r.rx_sub == SUB_LAST &&
            state_r.cfg.rx_enable && !state_r.rxd_s2 |=> rx_irq && state_r.fe;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error without rx irq"); // RULE14

    property p_rda_mask;
        !state_r.cfg.rx_data_irq_enable && !state_r.pe && !state_r.oe && !state_r.fe &&
            !state_r.brk |-> !rx_irq;
    endproperty
    a_rda_mask: assert property (p_rda_mask) else $error("masked data raised irq"); // RULE11

    property p_dma;
        state_r.rx_st == RX_STOP && state_r.tick && state_r.rx_sub == SUB_LAST &&
            state_r.cfg.rx_enable |=> dma_req && state_r.rx_data_available;
    endproperty
    a_dma: assert property (p_dma) else $error("dma request mismatch"); // RULE12

    property p_ninth;
        state_r.tx_st == TX_NINTH |-> txd == state_r.tx_ninth;
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit wrong"); // RULE15

endmodule : adu_uart

// >>> testbench/adu_node.sv
// Remote serial node: frame sender on rxd, frame catcher on txd
`timescale 1ns/1ps
module adu_node
#(
    parameter int BIT_CLKS = 32
)
(
    // Clock
    input wire logic clk_sys,
    // Serial lines
    input wire logic txd,
    output logic rxd,
    output logic cts_n
);
    logic [7:0] got_byte;
    logic got_ninth;
    int got_count;

    initial
    begin
        rxd = 1'b1;
        cts_n = 1'b1;
        got_count = 0;
    end

    // ----
    // Catch frames from the device, sampling mid-cell
    // ----
    always
    begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk_sys);
            if (i < 8)
                got_byte[i] = txd;
            else
                got_ninth = txd;
        end
        got_count++;
    end

    task automatic set_cts(input logic v);
        cts_n <= v;
    endtask : set_cts

    // Start, data LSB first, optional ninth bit, one stop, then idle
    task automatic send(input logic [7:0] b, input logic has9, input logic b9, input logic stp);
        logic [10:0] fr;
        fr = has9 ? {stp, b9, b, 1'b0} : {1'b1, stp, b, 1'b0};
        for (int i = 0; i < (has9 ? 11 : 10); i++)
        begin
            rxd <= fr[i];
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_sys);
    endtask : send

    // Short low pulse, then a whole frame time of idle line
    task automatic glitch(input int n);
        rxd <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (BIT_CLKS * 10) @(posedge clk_sys);
    endtask : glitch
endmodule : adu_node

// >>> testbench/tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb_top
    import adu_pkg::*;
;
    localparam int BIT_CLKS = 32;
    localparam logic [7:0] C1S [4] = '{8'h08, 8'h00, 8'h00, 8'h80};
    localparam logic [7:0] C0S [4] = '{8'hc0, 8'hc0, 8'hd0, 8'hc0};
    localparam logic [7:0] BYTES [4] = '{8'h5a, 8'h00, 8'h07, 8'h21};
    localparam logic [7:0] MASKS [4] = '{8'h80, 8'h18, 8'h40, 8'hff};
    localparam logic [7:0] EXPS [4] = '{8'h80, 8'h18, 8'h40, 8'h03};
    logic clk_sys;
    logic rst;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_data;
    logic tx_irq;
    logic rx_irq;
    logic dma_req;
    logic txd;
    logic rxd;
    logic cts_n;
    logic [7:0] d;
    int bad_count;
    int compares;

    adu_uart adu_uart_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .tx_irq(tx_irq),
        .rx_irq(rx_irq), .dma_req(dma_req), .txd(txd), .rxd(rxd), .cts_n(cts_n));
    adu_node #(.BIT_CLKS(BIT_CLKS)) adu_node_inst (.clk_sys(clk_sys), .txd(txd), .rxd(rxd),
        .cts_n(cts_n));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ----
    // Access and checking tasks
    // ----
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        v = rd_data;
    endtask : rd

    // Bounded wait for the node to catch frame number n
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (adu_node_inst.got_count != n && k < 2000)
        begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 2000)
        begin
            bad_count++;
            summarize();
        end
    endtask : wait_tx

    // ----
    // Main sequence
    // ----
    initial
    begin
        rst = 1'b1;
        addr = '0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("reset pins", {5'h00, txd, tx_irq, rx_irq | dma_req}, 8'h06);
        rd(REG_STAT0, d);
        chk("stat0 reset", d, 8'h07);
        rd(3'h7, d);
        chk("unmapped", d, 8'h00);
        wr(REG_BRG_HI, 8'h00);
        wr(REG_BRG_LO, 8'h02);
        wr(REG_DATA, 8'ha5);
        wr(REG_CTRL0, 8'h20);
        repeat (64) @(posedge clk_sys);
        chk("held tx off", {6'h00, txd, tx_irq}, 8'h02);
        rd(REG_STAT0, d);
        chk("stat0 full", d, 8'h03);
        wr(REG_CTRL0, 8'ha0);
        rd(REG_CTRL0, d);
        chk("ctrl0", d, 8'ha0);
        rd(REG_BRG_LO, d);
        chk("divisor", d, 8'h02);
        repeat (64) @(posedge clk_sys);
        chk("held cts", {7'h00, txd}, 8'h01);
        adu_node_inst.set_cts(1'b0);
        wait_tx(1);
        chk("tx byte", adu_node_inst.got_byte, 8'ha5);
        chk("tx stop", {6'h00, adu_node_inst.got_ninth, tx_irq}, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(REG_CTRL1, i < 2 ? 8'h00 : {1'b1, i == 2, 6'h00});
            wr(REG_CTRL0, i == 0 ? 8'h90 : 8'h98);
            wr(REG_DATA, 8'h07);
            wait_tx(i + 2);
            d = {7'h00, adu_node_inst.got_ninth};
            chk("tx ninth", d, {7'h00, i % 2 == 0});
        end
        wr(REG_CTRL1, 8'h00);
        wr(REG_CTRL0, 8'h82);
        wr(REG_DATA, 8'hc3);
        wait_tx(6);
        repeat (BIT_CLKS) @(posedge clk_sys);
        rd(REG_STAT0, d);
        chk("two stop busy", d & 8'h02, 8'h00);
        chk("tx byte 2", adu_node_inst.got_byte, 8'hc3);
        adu_node_inst.send(8'h3c, 1'b0, 1'b0, 1'b1);
        chk("rx off", {7'h00, dma_req}, 8'h00);
        wr(REG_CTRL0, 8'hc0);
        adu_node_inst.send(8'h3c, 1'b0, 1'b0, 1'b1);
        chk("rx pins", {6'h00, dma_req, rx_irq}, 8'h02);
        rd(REG_STAT0, d);
        chk("stat0 rx", d, 8'h86);
        rd(REG_DATA, d);
        chk("rx byte", d, 8'h3c);
        rd(REG_STAT0, d);
        chk("stat0 read", d, 8'h06);
        for (int i = 0; i < 4; i++)
        begin
            wr(REG_CTRL1, C1S[i]);
            wr(REG_CTRL0, C0S[i]);
            adu_node_inst.send(BYTES[i], i > 1, i == 3, i != 1);
            chk("rx irq", {7'h00, rx_irq}, {7'h00, i != 3});
            rd(i == 3 ? REG_STAT1 : REG_STAT0, d);
            chk("rx status", d & MASKS[i], EXPS[i]);
            rd(REG_DATA, d);
            chk("rx data", d, BYTES[i]);
            @(posedge clk_sys);
            chk("rx cleared", {7'h00, rx_irq | dma_req}, 8'h00);
        end
        wr(REG_CTRL1, 8'h00);
        adu_node_inst.send(8'h11, 1'b0, 1'b0, 1'b1);
        adu_node_inst.send(8'h22, 1'b0, 1'b0, 1'b1);
        chk("overrun irq", {7'h00, rx_irq}, 8'h01);
        rd(REG_STAT0, d);
        chk("overrun", d & 8'he0, 8'ha0);
        rd(REG_DATA, d);
        chk("overrun data", d, 8'h22);
        adu_node_inst.glitch(4);
        chk("false start", {7'h00, dma_req}, 8'h00);
        summarize();
    end
endmodule : tb_top
